// [design/scr_device.sv]
// Synthesizer configuration bank with its two-wire write-only loader.
// Assumes the link wires are asynchronous to clk_in and that the
// observation inputs come from logic on clk_in.
//
// Design decision made here: the registered decodes of ratio, current, enables and test points.
`timescale 1ns/1ps
`include "scr_regs.svh"

module scr_device import scr_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = `SCR_DEV_ADDR
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Serial link
  scr_if.device link,
  // Synthesizer signals offered to the test points
  input wire logic pump_up_in,
  input wire logic pump_down_in,
  input wire logic m_cnt_in,
  input wire logic n_cnt_in,
  input wire logic prescaler_in,
  input wire logic modulus_in,
  // Feedback and reference divider control
  output logic [16:0] divide_ratio_out,
  output logic [3:0] ref_div_code_out,
  output logic [8:0] ref_div_ratio_out,
  // Phase detector control
  output logic [1:0] pump_current_out,
  output logic [8:0] pump_current_ua_out,
  output logic phase_det_disable_out,
  // Oscillator control
  output logic [1:0] osc_sel_out,
  output logic low_osc_en_out,
  output logic high_osc_en_out,
  // Test points
  output logic [1:0] probe_sel_out,
  output logic probe_out_a_out,
  output logic probe_out_b_out
);

  ////////////////////////////////////////////////////////////////////////////
  // State and local decode

  scr_dev_st_t q;
  scr_dev_st_t d;

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [3:0] ref_code;
  logic [1:0] pump_code;
  logic [1:0] probe_code;
  logic [1:0] osc_code;

  // Synchronised wire levels, never the first stage
  assign scl_s = q.scl_sync[1];
  assign sda_s = q.sda_sync[1];

  // Edge and bus condition detection
  assign scl_rise = scl_s && !q.scl_prev;
  assign scl_fall = !scl_s && q.scl_prev;
  assign start_seen = scl_s && q.scl_prev && q.sda_prev && !sda_s;
  assign stop_seen = scl_s && q.scl_prev && !q.sda_prev && sda_s;

  // Field extraction from the bank
  assign ref_code = q.bank[`SCR_REG_TOP_REF][`SCR_REF_MSB:0];
  assign pump_code = q.bank[`SCR_REG_PUMP_OSC][`SCR_PUMP_MSB -: 2];
  assign probe_code = q.bank[`SCR_REG_PUMP_OSC][`SCR_PROBE_MSB -: 2];
  assign osc_code = q.bank[`SCR_REG_PUMP_OSC][`SCR_OSC_MSB -: 2];

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  // Link sequencer, bank update and registered decodes
  always_comb begin
    d = q;
    d.scl_sync = {q.scl_sync[0], link.scl};
    d.sda_sync = {q.sda_sync[0], link.sda};
    d.scl_prev = scl_s;
    d.sda_prev = sda_s;

    // Frame framing wins over bit handling
    if (start_seen) begin
      d.fsm = SCR_DEV_ADDR;
      d.bit_cnt = 4'h0;
      d.reg_idx = 3'h0;
      d.sda_low = 1'b0;
    end else if (stop_seen) begin
      d.fsm = SCR_DEV_IDLE;
      d.sda_low = 1'b0;
    end else begin
      case (q.fsm)
        SCR_DEV_ADDR, SCR_DEV_DATA: begin
          // Sample data while the clock is high
          if (scl_rise) begin
            d.shift = {q.shift[6:0], sda_s};
            d.bit_cnt = q.bit_cnt + 4'h1;
          end else if (scl_fall && q.bit_cnt == 4'h8) begin
            if (q.fsm == SCR_DEV_ADDR) begin
              // Only a write to our address is answered
              if (q.shift[7:1] == DEV_ADDR && !q.shift[0]) begin
                d.sda_low = 1'b1;
                d.fsm = SCR_DEV_ACK_ADDR;
              end else begin
                d.fsm = SCR_DEV_IGNORE;
              end
            end else begin
              // Bytes land in order; beyond the last they are acked and dropped
              if (q.reg_idx < `SCR_NUM_REGS) begin
                d.bank[q.reg_idx[1:0]] = q.shift;
                d.reg_idx = q.reg_idx + 3'h1;
              end
              d.sda_low = 1'b1;
              d.fsm = SCR_DEV_ACK_DATA;
            end
          end
        end
        SCR_DEV_ACK_ADDR, SCR_DEV_ACK_DATA: begin
          // Release the acknowledge after its clock pulse
          if (scl_fall) begin
            d.sda_low = 1'b0;
            d.bit_cnt = 4'h0;
            d.fsm = SCR_DEV_DATA;
          end
        end
        SCR_DEV_IDLE, SCR_DEV_IGNORE: begin
          d.sda_low = 1'b0;
        end
        default: begin
          d.fsm = SCR_DEV_IDLE;
          d.sda_low = 1'b0;
        end
      endcase
    end

    // Reference divide ratio, zero for the undefined code
    if (ref_code == `SCR_REF_UNDEF) begin
      d.ref_ratio = 9'h000;
    end else if (!ref_code[3]) begin
      d.ref_ratio = 9'h002 << ref_code[2:0];
    end else begin
      d.ref_ratio = 9'h005 << (ref_code[2:0] - 3'h1);
    end

    // Charge pump current in microamperes
    d.pump_ua = 9'h064 + 9'h064 * {7'h00, pump_code};

    // Oscillator enables, both off for the undefined code
    d.low_en = (osc_code == 2'h1);
    d.high_en = (osc_code == 2'h2);

    // Test point routing
    case (probe_code)
      2'h1: begin
        d.probe_a = pump_up_in;
        d.probe_b = pump_down_in;
      end
      2'h2: begin
        d.probe_a = m_cnt_in;
        d.probe_b = n_cnt_in;
      end
      2'h3: begin
        d.probe_a = prescaler_in;
        d.probe_b = modulus_in;
      end
      default: begin
        d.probe_a = 1'b0;
        d.probe_b = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  // Synchronous reset; wires assumed released
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      q <= '0;
      q.scl_sync <= 2'h3;
      q.sda_sync <= 2'h3;
      q.scl_prev <= 1'b1;
      q.sda_prev <= 1'b1;
      q.fsm <= SCR_DEV_IDLE;
      q.bank <= {4{`SCR_BANK_RESET}};
      q.pump_ua <= 9'h064;
      q.ref_ratio <= 9'h002;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Open-drain data pin, driven only to pull low
  assign link.sda_dev_out = 1'b0;
  assign link.sda_dev_oe = q.sda_low;

  // Single 17-bit feedback word; top bits of registers 0 and 2 unused
  assign divide_ratio_out = {
    q.bank[`SCR_REG_TOP_REF][`SCR_RATIO_HI_MSB -: 2],
    q.bank[`SCR_REG_FB_HIGH][`SCR_RATIO_HI_MSB:0],
    q.bank[`SCR_REG_FB_LOW]
  };

  // Reference divider
  assign ref_div_code_out = ref_code;
  assign ref_div_ratio_out = q.ref_ratio;

  // Phase detector; register 2 bit 4 and register 3 bit 0 reach nothing
  assign pump_current_out = pump_code;
  assign pump_current_ua_out = q.pump_ua;
  assign phase_det_disable_out = q.bank[`SCR_REG_PUMP_OSC][`SCR_PDIS_BIT];

  // Oscillators
  assign osc_sel_out = osc_code;
  assign low_osc_en_out = q.low_en;
  assign high_osc_en_out = q.high_en;

  // Test points
  assign probe_sel_out = probe_code;
  assign probe_out_a_out = q.probe_a;
  assign probe_out_b_out = q.probe_b;

endmodule

// [design/scr_host.sv]
// Loader that writes the four configuration bytes over the two-wire link.
// Assumes software on AHB-Lite, one slave, word transfers only.
`timescale 1ns/1ps
`include "scr_regs.svh"

module scr_host import scr_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = `SCR_DEV_ADDR,
  parameter logic [7:0] QTR_CYC = 8'(`SCR_SCL_QTR_CYC)
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  // Serial link
  scr_if.host link
);

  ////////////////////////////////////////////////////////////////////////////
  // State and decode

  scr_host_st_t q;
  scr_host_st_t d;

  logic tick;
  logic busy;
  logic ap_take;
  logic go;
  logic [7:0] next_byte;

  assign busy = (q.fsm != SCR_HOST_IDLE);
  assign tick = (q.qcnt == QTR_CYC - 8'h01);
  assign ap_take = hsel_in && hready_in && htrans_in[1] && hsize_in == 3'h2;
  assign go = q.ap_valid && q.ap_write && q.ap_addr == `SCR_AHB_CTRL
    && hwdata_in[`SCR_CTRL_GO_BIT] && !busy;

  // Byte for the following slot; fixed top bits forced here
  always_comb begin
    case (q.byte_idx + 3'h1)
      3'h1: next_byte = {1'b0, q.data[6:0]};
      3'h2: next_byte = q.data[15:8];
      3'h3: next_byte = {1'b1, q.data[22:16]};
      3'h4: next_byte = q.data[31:24];
      default: next_byte = 8'hff;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d = q;
    d.sda_sync = {q.sda_sync[0], link.sda};
    d.qcnt = (busy && !tick) ? q.qcnt + 8'h01 : 8'h00;

    // Register bus: capture address phase, read data ready for data phase
    d.ap_valid = ap_take;
    d.ap_write = hwrite_in;
    d.ap_addr = haddr_in[7:0];
    case (haddr_in[7:0])
      `SCR_AHB_DATA: d.rdata = q.data;
      `SCR_AHB_STATUS: d.rdata = {29'h0, q.refused, q.nack, busy};
      default: d.rdata = 32'h0;
    endcase
    if (q.ap_valid && q.ap_write && q.ap_addr == `SCR_AHB_DATA && !busy) begin
      d.data = hwdata_in;
    end

    case (q.fsm)
      SCR_HOST_IDLE: begin
        d.scl_low = 1'b0;
        d.sda_low = 1'b0;
        if (go) begin
          d.nack = 1'b0;
          d.phase = 2'h0;
          // Undefined divider or oscillator codes are never sent
          if (q.data[19:16] == `SCR_REF_UNDEF || q.data[26:25] == `SCR_OSC_UNDEF) begin
            d.refused = 1'b1;
          end else begin
            d.refused = 1'b0;
            d.fsm = SCR_HOST_START;
          end
        end
      end
      SCR_HOST_START: begin
        // Data falls while clock high, then clock falls
        if (tick) begin
          d.phase = q.phase + 2'h1;
          if (q.phase == 2'h0) d.sda_low = 1'b1;
          if (q.phase == 2'h1) d.scl_low = 1'b1;
          if (q.phase == 2'h3) begin
            d.fsm = SCR_HOST_BIT;
            d.shift = {DEV_ADDR, 1'b0};
            d.bit_idx = 4'h0;
            d.byte_idx = 3'h0;
          end
        end
      end
      SCR_HOST_BIT: begin
        // Quarter 0 sets data, 1 raises clock, 2 samples, 3 lowers clock
        if (tick) begin
          d.phase = q.phase + 2'h1;
          case (q.phase)
            2'h0: d.sda_low = (q.bit_idx == 4'h8) ? 1'b0 : !q.shift[7];
            2'h1: d.scl_low = 1'b0;
            2'h2: d.ack_bad = q.sda_sync[1];
            default: begin
              d.scl_low = 1'b1;
              if (q.bit_idx != 4'h8) begin
                d.shift = {q.shift[6:0], 1'b0};
                d.bit_idx = q.bit_idx + 4'h1;
              end else if (q.ack_bad) begin
                d.nack = 1'b1;
                d.fsm = SCR_HOST_STOP;
              end else if (q.byte_idx == 3'h4) begin
                d.fsm = SCR_HOST_STOP;
              end else begin
                d.byte_idx = q.byte_idx + 3'h1;
                d.shift = next_byte;
                d.bit_idx = 4'h0;
              end
            end
          endcase
        end
      end
      SCR_HOST_STOP: begin
        // Data low, clock rises, data rises
        if (tick) begin
          d.phase = q.phase + 2'h1;
          if (q.phase == 2'h0) d.sda_low = 1'b1;
          if (q.phase == 2'h1) d.scl_low = 1'b0;
          if (q.phase == 2'h2) d.sda_low = 1'b0;
          if (q.phase == 2'h3) d.fsm = SCR_HOST_IDLE;
        end
      end
      default: d.fsm = SCR_HOST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      q <= '0;
      q.sda_sync <= 2'h3;
      q.fsm <= SCR_HOST_IDLE;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Zero-wait slave, always OKAY
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign hrdata_out = q.rdata;

  // Open-drain wires, driven only to pull low
  assign link.scl_host_out = 1'b0;
  assign link.scl_host_oe = q.scl_low;
  assign link.sda_host_out = 1'b0;
  assign link.sda_host_oe = q.sda_low;

endmodule

// [design/scr_if.sv]
// Two-wire serial link between the loader and the configuration bank.
// Assumes pull-ups on both wires; a wire is low while any end drives it low.
`timescale 1ns/1ps

interface scr_if;
  // Host drives
  logic scl_host_out;
  logic scl_host_oe;
  logic sda_host_out;
  logic sda_host_oe;
  // Device drives
  logic sda_dev_out;
  logic sda_dev_oe;
  // Resolved wire levels
  logic scl;
  logic sda;

  // Open-drain resolution with pull-up
  assign scl = !(scl_host_oe && !scl_host_out);
  assign sda = !(sda_host_oe && !sda_host_out) && !(sda_dev_oe && !sda_dev_out);

  modport device (input scl, input sda, output sda_dev_out, output sda_dev_oe);
  modport host (input sda, output scl_host_out, output scl_host_oe,
    output sda_host_out, output sda_host_oe);
endinterface

// [design/scr_pkg.sv]
// Types shared by both ends of the synthesizer configuration link.
// Assumes scr_regs.svh is on the include path.
`include "scr_regs.svh"

package scr_pkg;

  // Device end receive sequencer
  typedef enum logic [2:0] {
    SCR_DEV_IDLE,
    SCR_DEV_ADDR,
    SCR_DEV_ACK_ADDR,
    SCR_DEV_DATA,
    SCR_DEV_ACK_DATA,
    SCR_DEV_IGNORE
  } scr_dev_fsm_t;

  // Host end transmit sequencer
  typedef enum logic [1:0] {
    SCR_HOST_IDLE,
    SCR_HOST_START,
    SCR_HOST_BIT,
    SCR_HOST_STOP
  } scr_host_fsm_t;

  // Whole state of the device end
  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_prev;
    logic sda_prev;
    scr_dev_fsm_t fsm;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [2:0] reg_idx;
    logic sda_low;
    logic [3:0][7:0] bank;
    logic [8:0] ref_ratio;
    logic [8:0] pump_ua;
    logic low_en;
    logic high_en;
    logic probe_a;
    logic probe_b;
  } scr_dev_st_t;

  // Whole state of the host end
  typedef struct packed {
    logic [1:0] sda_sync;
    scr_host_fsm_t fsm;
    logic [7:0] qcnt;
    logic [1:0] phase;
    logic [3:0] bit_idx;
    logic [2:0] byte_idx;
    logic [7:0] shift;
    logic ack_bad;
    logic scl_low;
    logic sda_low;
    logic [31:0] data;
    logic nack;
    logic refused;
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    logic [31:0] rdata;
  } scr_host_st_t;

endpackage

// [design/scr_regs.svh]
// Offsets, field positions, reset values and timing counts of the
// synthesizer configuration bank and of its serial loader.
// Assumes inclusion by bare name from the package and both ends.
`ifndef SCR_REGS_SVH
`define SCR_REGS_SVH

// Device register indices, written in this order after the address byte
`define SCR_REG_FB_HIGH 2'h0
`define SCR_REG_FB_LOW 2'h1
`define SCR_REG_TOP_REF 2'h2
`define SCR_REG_PUMP_OSC 2'h3
`define SCR_NUM_REGS 3'h4
`define SCR_BANK_RESET 8'h00

// Field positions inside the device registers
`define SCR_TOP_BIT 7
`define SCR_RATIO_HI_MSB 6
`define SCR_REF_MSB 3
`define SCR_PUMP_MSB 7
`define SCR_PROBE_MSB 5
`define SCR_PDIS_BIT 3
`define SCR_OSC_MSB 2
`define SCR_REF_UNDEF 4'h8
`define SCR_OSC_UNDEF 2'h3

// Serial address of the device; value is arbitrary
`define SCR_DEV_ADDR 7'h60

// Controller register byte offsets on the AHB-Lite side
`define SCR_AHB_CTRL 8'h00
`define SCR_AHB_DATA 8'h04
`define SCR_AHB_STATUS 8'h08
`define SCR_CTRL_GO_BIT 0

// Serial clock timing
`define SCR_CLK_PERIOD_NS 40
`define SCR_SCL_MIN_PERIOD_NS 2500
`define SCR_SCL_QTR_CYC \
  ((`SCR_SCL_MIN_PERIOD_NS / 4 + `SCR_CLK_PERIOD_NS - 1) / `SCR_CLK_PERIOD_NS)

`endif

// [tb/scr_link_monitor.sv]
// Concurrent checks on the link wires and the bank's decoded outputs.
// Assumes instantiation beside the link interface in the bench top.
`timescale 1ns/1ps

module scr_link_monitor (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Link wires
  input wire logic scl,
  input wire logic sda_dev_oe,
  // Synthesizer taps
  input wire logic pump_up_in,
  input wire logic pump_down_in,
  input wire logic m_cnt_in,
  input wire logic n_cnt_in,
  input wire logic prescaler_in,
  input wire logic modulus_in,
  // Bank outputs
  input wire logic [16:0] divide_ratio_out,
  input wire logic [3:0] ref_div_code_out,
  input wire logic [8:0] ref_div_ratio_out,
  input wire logic [1:0] pump_current_out,
  input wire logic [8:0] pump_current_ua_out,
  input wire logic phase_det_disable_out,
  input wire logic [1:0] osc_sel_out,
  input wire logic low_osc_en_out,
  input wire logic high_osc_en_out,
  input wire logic [1:0] probe_sel_out,
  input wire logic probe_out_a_out,
  input wire logic probe_out_b_out
);
  logic [5:0] taps;
  logic [7:0] per_q;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  // Reference divide ratio for a code, zero for the undefined one
  function automatic logic [8:0] ref_of(input logic [3:0] c);
    if (c == 4'h8) return 9'h000;
    return c[3] ? 9'(9'h005 << (c - 4'h9)) : 9'(9'h002 << c);
  endfunction

  // Test point level for a select value; b picks the second point
  function automatic logic probe_of(input logic [1:0] s, input logic [5:0] v, input logic b);
    case (s)
      2'h1: return b ? v[4] : v[5];
      2'h2: return b ? v[2] : v[3];
      2'h3: return b ? v[0] : v[1];
      default: return 1'b0;
    endcase
  endfunction

  assign taps = {pump_up_in, pump_down_in, m_cnt_in, n_cnt_in, prescaler_in, modulus_in};

  // Cycles since the last serial clock rise, saturating
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || $rose(scl)) begin
      per_q <= reset_n_in ? 8'h00 : 8'hff;
    end else if (per_q != 8'hff) begin
      per_q <= per_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  property p_ref_decode;
    ref_div_ratio_out == ref_of($past(ref_div_code_out));
  endproperty
  a_ref_decode: assert property (p_ref_decode) else $error("ref ratio decode wrong");
  property p_pump_decode;
    pump_current_ua_out == 9'h064 * ({7'h00, $past(pump_current_out)} + 9'h001);
  endproperty
  a_pump_decode: assert property (p_pump_decode) else $error("pump current wrong");
  property p_osc_decode;
    {low_osc_en_out, high_osc_en_out} == {$past(osc_sel_out) == 2'h1, $past(osc_sel_out) == 2'h2};
  endproperty
  a_osc_decode: assert property (p_osc_decode) else $error("oscillator enables wrong");
  property p_probe_a;
    probe_out_a_out == probe_of($past(probe_sel_out), $past(taps), 1'b0);
  endproperty
  a_probe_a: assert property (p_probe_a) else $error("first test point wrong");
  property p_probe_b;
    probe_out_b_out == probe_of($past(probe_sel_out), $past(taps), 1'b1);
  endproperty
  a_probe_b: assert property (p_probe_b) else $error("second test point wrong");
  property p_scl_rate;
    $rose(scl) |-> per_q >= 8'h3e;
  endproperty
  a_scl_rate: assert property (p_scl_rate) else $error("serial clock too fast");
  property p_ratio_low;
    $changed(divide_ratio_out) || $changed(ref_div_code_out) |-> !scl;
  endproperty
  a_ratio_low: assert property (p_ratio_low) else $error("ratio changed with clock high");
  property p_ctrl_low;
    $changed({pump_current_out, probe_sel_out, phase_det_disable_out, osc_sel_out}) |-> !scl;
  endproperty
  a_ctrl_low: assert property (p_ctrl_low) else $error("control changed with clock high");

  // Main scenarios reached
  c_ack: cover property ($rose(sda_dev_oe));
  c_ref_top: cover property (ref_div_code_out == 4'hf);
  c_high_osc: cover property (high_osc_en_out);
endmodule

// [tb/tb_synth_config_regs.sv]
// Bench top: loader and bank joined by the link, driven over AHB-Lite.
// Assumes design package, header, interface and both ends compiled first.
`timescale 1ns/1ps
`include "scr_regs.svh"

module tb_synth_config_regs;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hresp;
  logic [31:0] hrdata;
  logic [5:0] taps = 6'h00;
  logic [16:0] ratio;
  logic [3:0] ref_code;
  logic [8:0] ref_ratio;
  logic [1:0] pump;
  logic [8:0] pump_ua;
  logic pdis;
  logic [1:0] osc;
  logic low_en;
  logic high_en;
  logic [1:0] psel;
  logic pa;
  logic pb;
  logic [47:0] outs;
  logic [45:0] bits_q = 46'h0;
  int nbits = 0;
  int cycles = 0;
  int n_errors = 0;
  int num_checks = 0;

  scr_if link ();
  scr_host i_scr_host (.clk_in(clk_in), .reset_n_in(reset_n_in), .hsel_in(1'b1),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hready), .hreadyout_out(hready), .hresp_out(hresp),
    .hrdata_out(hrdata), .link(link.host));
  scr_device i_scr_device (.clk_in(clk_in), .reset_n_in(reset_n_in), .link(link.device),
    .pump_up_in(taps[5]), .pump_down_in(taps[4]), .m_cnt_in(taps[3]), .n_cnt_in(taps[2]),
    .prescaler_in(taps[1]), .modulus_in(taps[0]), .divide_ratio_out(ratio),
    .ref_div_code_out(ref_code), .ref_div_ratio_out(ref_ratio), .pump_current_out(pump),
    .pump_current_ua_out(pump_ua), .phase_det_disable_out(pdis), .osc_sel_out(osc),
    .low_osc_en_out(low_en), .high_osc_en_out(high_en), .probe_sel_out(psel),
    .probe_out_a_out(pa), .probe_out_b_out(pb));
  scr_link_monitor i_scr_link_monitor (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .scl(link.scl), .sda_dev_oe(link.sda_dev_oe), .pump_up_in(taps[5]),
    .pump_down_in(taps[4]), .m_cnt_in(taps[3]), .n_cnt_in(taps[2]), .prescaler_in(taps[1]),
    .modulus_in(taps[0]), .divide_ratio_out(ratio), .ref_div_code_out(ref_code),
    .ref_div_ratio_out(ref_ratio), .pump_current_out(pump), .pump_current_ua_out(pump_ua),
    .phase_det_disable_out(pdis), .osc_sel_out(osc), .low_osc_en_out(low_en),
    .high_osc_en_out(high_en), .probe_sel_out(psel), .probe_out_a_out(pa),
    .probe_out_b_out(pb));

  assign outs = {ratio, ref_code, ref_ratio, pump, pump_ua, pdis, osc, low_en, high_en, psel};

  ////////////////////////////////////////////////////////////////////////
  // Clock, random taps and hang limit
  always #20 clk_in = ~clk_in;
  always @(posedge clk_in) taps <= 6'($urandom());
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 90000) begin
      n_errors++;
      stop_test();
    end
  end

  // Wire capture: count restarts at START, one bit per clock rise
  always @(negedge link.sda) if (link.scl) nbits = 0;
  always @(posedge link.scl) begin
    bits_q = {bits_q[44:0], link.sda};
    nbits = nbits + 1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Expected frame: address+W, four bytes (first and third with forced top bits), acks, STOP rise
  function automatic logic [45:0] exp_wire(input logic [31:0] w);
    return {`SCR_DEV_ADDR, 2'b00, 1'b0, w[6:0], 1'b0, w[15:8], 2'b01, w[22:16], 1'b0,
      w[31:24], 2'b00};
  endfunction

  // Expected port values after a frame carrying w
  function automatic logic [47:0] exp_out(input logic [31:0] w);
    logic [8:0] rr;
    rr = w[19] ? 9'(9'h005 << (w[19:16] - 4'h9)) : 9'(9'h002 << w[19:16]);
    return {w[22:21], w[6:0], w[15:8], w[19:16], rr, w[31:30],
      9'h064 * ({7'h00, w[31:30]} + 9'h001), w[27], w[26:25], w[26:25] == 2'h1,
      w[26:25] == 2'h2, w[29:28]};
  endfunction

  task automatic chk_port(input logic [47:0] got, input logic [47:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
    chk_port({16'h0, got}, {16'h0, exp});
  endtask

  // One AHB-Lite single word transfer
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk_in);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge clk_in);
    while (hready !== 1'b1) @(posedge clk_in);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk_in);
    while (hready !== 1'b1) @(posedge clk_in);
    rd = hrdata;
    chk_bus({31'h0, hresp}, 32'h0);
  endtask

  task automatic stop_test();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] w;
    logic [31:0] rd;
    logic [47:0] prev;
    logic bad;
    void'($urandom(32'h7b71f8b2));
    repeat (12) @(posedge clk_in);
    reset_n_in <= 1'b1;
    bus(1'b0, 8'h08, 32'h0, rd);
    chk_bus(rd, 32'h0);
    bus(1'b1, 8'h0c, 32'hffffffff, rd);
    bus(1'b0, 8'h0c, 32'h0, rd);
    chk_bus(rd, 32'h0);
    chk_port(outs, exp_out(32'h0));
    // Codes 0..15, every pump, probe and oscillator value; two refusals
    for (int i = 0; i <= 17; i++) begin
      w = (i == 16) ? 32'hfdffffff : $urandom();
      if (i < 16) w[19:16] = i[3:0];
      if (i < 16) w[31:28] = {i[1:0], i[3:2]};
      w[26:25] = (i == 17) ? 2'h3 : 2'(i % 3);
      bad = (i == 8) || (i == 17);
      prev = outs;
      nbits = 0;
      bus(1'b1, 8'h04, w, rd);
      bus(1'b1, 8'h00, 32'h1, rd);
      if (i == 3) bus(1'b1, 8'h04, ~w, rd);
      do bus(1'b0, 8'h08, 32'h0, rd); while (rd[0] === 1'b1);
      chk_bus(rd, {29'h0, bad, 2'b00});
      bus(1'b0, 8'h04, 32'h0, rd);
      chk_bus(rd, w);
      if (bad) begin
        chk_port(outs, prev);
        chk_port(48'(nbits), 48'h0);
      end else begin
        chk_port(outs, exp_out(w));
        chk_port({2'b00, bits_q}, {2'b00, exp_wire(w)});
        chk_port(48'(nbits), 48'h2e);
      end
    end
    stop_test();
  end
endmodule
